// ---- logic/dfr_pkg.sv ----
// Package of register map, field layout and state codes for the readback
package dfr_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_RESULT_LO = 12'h0300;
  localparam logic [11:0] IDX_RESULT_HI = 12'h0304;
  localparam logic [11:0] IDX_TIE_DATA  = 12'h0306;
  localparam logic [11:0] IDX_CTRL      = 12'h0308;
  localparam logic [11:0] IDX_TIE_CTRL  = 12'h030A;

  localparam logic [11:0] ADDR_RESULT_LO = {IDX_RESULT_LO[9:0], 2'b00};
  localparam logic [11:0] ADDR_RESULT_HI = {IDX_RESULT_HI[9:0], 2'b00};
  localparam logic [11:0] ADDR_TIE_DATA  = {IDX_TIE_DATA[9:0], 2'b00};
  localparam logic [11:0] ADDR_CTRL      = {IDX_CTRL[9:0], 2'b00};
  localparam logic [11:0] ADDR_TIE_CTRL  = {IDX_TIE_CTRL[9:0], 2'b00};

  // Read control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_MSB = 2;
  localparam int CTRL_REQ_BIT = 4;

  // Reset values
  localparam logic [2:0]  SEL_RESET      = 3'h0;
  localparam logic [31:0] TIE_DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // Loop state codes on the loop_state input
  localparam logic [1:0] LS_NORMAL   = 2'h0;
  localparam logic [1:0] LS_HOLDOVER = 2'h1;
  localparam logic [1:0] LS_NCO      = 2'h2;

  // Low selector bit pairs
  localparam logic [1:0] SEL_INT = 2'h0;
  localparam logic [1:0] SEL_HOF = 2'h1;
  localparam logic [1:0] SEL_PIS = 2'h2;
  localparam logic [1:0] SEL_PP  = 2'h3;

  // Phase error data weight in picoseconds per LSB
  localparam int TIE_LSB_PS = 1000;

  typedef enum logic [1:0] {rb_idle, rb_store, rb_clear} dfr_rb_state_t;

endpackage

// ---- logic/dfr_qty_if.sv ----
// Interface carrying live loop quantities into a snapshot bank and back
`timescale 1ns/100ps
`default_nettype none
interface dfr_qty_if #(parameter int W = 40) ();
  logic [W-1:0] live_int;
  logic [W-1:0] live_hof;
  logic [W-1:0] live_pis;
  logic [W-1:0] live_pp;
  logic [W-1:0] held_int;
  logic [W-1:0] held_hof;
  logic [W-1:0] held_pis;
  logic [W-1:0] held_pp;

  modport bank (
    input  live_int, live_hof, live_pis, live_pp,
    output held_int, held_hof, held_pis, held_pp
  );
  modport user (
    output live_int, live_hof, live_pis, live_pp,
    input  held_int, held_hof, held_pis, held_pp
  );
endinterface
`default_nettype wire

// ---- logic/dfr_snapshot.sv ----
// Snapshot bank that tracks loop quantities and freezes them on demand
`timescale 1ns/100ps
`default_nettype none
module dfr_snapshot #(
  parameter int W = 40
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Track while high, hold while low
  input  wire logic track,
  // Quantities
  dfr_qty_if.bank   q
);

  logic [W-1:0] int_ff;
  logic [W-1:0] hof_ff;
  logic [W-1:0] pis_ff;
  logic [W-1:0] pp_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_ff <= '0;
      hof_ff <= '0;
      pis_ff <= '0;
      pp_ff  <= '0;
    end
    else if (track)
    begin
      int_ff <= q.live_int;
      hof_ff <= q.live_hof;
      pis_ff <= q.live_pis;
      pp_ff  <= q.live_pp;
    end
  end

  assign q.held_int = int_ff;
  assign q.held_hof = hof_ff;
  assign q.held_pis = pis_ff;
  assign q.held_pp  = pp_ff;

endmodule
`default_nettype wire

// ---- logic/dfr_freq_readback.sv ----
// Frequency offset readback and phase error data registers behind APB
//
// How it works
// RQ1: Writing request bit 4 starts manual readback
// RQ2: Result stored first, request bit cleared after
// RQ3: Host sets request bit; only device clears
// RQ4: Host polls request bit before writing again
// RQ5: Selector bits 2:0 pick manual/auto quantity
// RQ6: Normal state: integral, holdover, sum, proportional
// RQ7: Holdover, selector 0xx: holdover filter output
// RQ8: Holdover 100: integral latched before holdover
// RQ9: Holdover 101/110/111: filter, latched sum, proportional
// RQ10: NCO reads return values latched on entry
// RQ11: NCO 110: sum or filter by prior state
// RQ12: 32-bit phase error argument or result
// RQ13: Phase error LSB weighs one nanosecond
// RQ14: Host touches phase data only when idle
// RQ15: Reserved control bits read zero
`timescale 1ns/100ps
`default_nettype none
module dfr_freq_readback #(
  parameter int W = 40
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Loop quantities and state
  input  wire logic [W-1:0] integral_accumulator,
  input  wire logic [W-1:0] holdover_filter_out,
  input  wire logic [W-1:0] pi_sum,
  input  wire logic [W-1:0] p_part,
  input  wire logic [1:0]   loop_state,
  input  wire logic         nco_auto_read,
  // Phase error operation
  input  wire logic [1:0]   tie_action_field,
  input  wire logic         tie_result_valid,
  input  wire logic [31:0]  tie_result,
  output logic      [31:0]  tie_argument,
  // Status
  output logic              readback_busy
);

  if (W < 33 || W > 64)
  begin : g_width_check
    $error("dfr_freq_readback: W must lie in 33..64");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0]             sel_ff;
  logic                   sem_ff;
  logic [W-1:0]           result_ff;
  logic [31:0]            tie_ff;
  logic [1:0]             prev_state_ff;
  logic                   auto_pend_ff;
  logic                   manual_ff;
  dfr_pkg::dfr_rb_state_t state_ff;
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;

  dfr_qty_if #(.W(W)) ho_q ();
  dfr_qty_if #(.W(W)) nco_q ();

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire apb_setup = psel & ~penable;
  wire apb_take  = psel & penable & pready_ff;
  wire wr_take   = apb_take & pwrite;
  wire rd_setup  = apb_setup & ~pwrite;

  wire hit_res_lo  = (paddr == dfr_pkg::ADDR_RESULT_LO);
  wire hit_res_hi  = (paddr == dfr_pkg::ADDR_RESULT_HI);
  wire hit_tie     = (paddr == dfr_pkg::ADDR_TIE_DATA);
  wire hit_ctrl    = (paddr == dfr_pkg::ADDR_CTRL);
  wire hit_tie_ctl = (paddr == dfr_pkg::ADDR_TIE_CTRL);
  wire hit_any     = hit_res_lo | hit_res_hi | hit_tie | hit_ctrl
                   | hit_tie_ctl;

  wire ctrl_wr = wr_take & hit_ctrl;
  wire tie_wr  = wr_take & hit_tie;

  // Control read: reserved bits 7:5 and 3 stay zero
  wire [31:0] ctrl_word = {27'h000_0000, sem_ff, 1'b0, sel_ff}; // RQ15

  wire [31:0] res_hi_word = 32'(result_ff[W-1:32]);

  wire [31:0] rd_mux =
      hit_res_lo  ? result_ff[31:0] :
      hit_res_hi  ? res_hi_word :
      hit_tie     ? tie_ff :
      hit_ctrl    ? ctrl_word :
      hit_tie_ctl ? {30'h0000_0000, tie_action_field} :
                    dfr_pkg::ZERO_WORD;

  // No wait state: ready rises in the first access cycle after each setup
  wire        nxt_pready  = apb_setup;
  wire        nxt_pslverr = apb_setup & ~hit_any;
  wire [31:0] nxt_prdata  = rd_setup ? rd_mux : prdata_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= dfr_pkg::ZERO_WORD;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot banks: holdover bank frozen in holdover or NCO, NCO bank frozen in NCO only

  assign ho_q.live_int = integral_accumulator;
  assign ho_q.live_hof = holdover_filter_out;
  assign ho_q.live_pis = pi_sum;
  assign ho_q.live_pp  = p_part;

  wire in_ho  = (loop_state == dfr_pkg::LS_HOLDOVER);
  wire in_nco = (loop_state == dfr_pkg::LS_NCO);

  // From holdover, NCO keeps the pre-holdover values and filter output
  assign nco_q.live_int = in_ho ? ho_q.held_int : integral_accumulator;
  assign nco_q.live_hof = holdover_filter_out;
  assign nco_q.live_pis = in_ho ? holdover_filter_out : pi_sum; // RQ11
  assign nco_q.live_pp  = in_ho ? ho_q.held_pp : p_part;

  dfr_snapshot #(.W(W)) u_ho_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .track   (~in_ho & ~in_nco),
    .q       (ho_q.bank)
  );

  dfr_snapshot #(.W(W)) u_nco_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .track   (~in_nco),
    .q       (nco_q.bank) // RQ10
  );

  ////////////////////////////////////////////////////////////////////////////
  // Quantity selection

  wire       sel_hi = sel_ff[2];
  wire [1:0] sel_lo = sel_ff[1:0];

  wire [W-1:0] normal_val = // RQ6
      (sel_lo == dfr_pkg::SEL_INT) ? integral_accumulator :
      (sel_lo == dfr_pkg::SEL_HOF) ? holdover_filter_out :
      (sel_lo == dfr_pkg::SEL_PIS) ? pi_sum :
                                     p_part;

  wire [W-1:0] ho_val =
      !sel_hi                      ? holdover_filter_out : // RQ7
      (sel_lo == dfr_pkg::SEL_INT) ? ho_q.held_int :       // RQ8
      (sel_lo == dfr_pkg::SEL_HOF) ? holdover_filter_out : // RQ9
      (sel_lo == dfr_pkg::SEL_PIS) ? ho_q.held_pis :
                                     ho_q.held_pp;

  wire [W-1:0] nco_val = // RQ10
      (sel_lo == dfr_pkg::SEL_INT) ? nco_q.held_int :
      (sel_lo == dfr_pkg::SEL_HOF) ? nco_q.held_hof :
      (sel_lo == dfr_pkg::SEL_PIS) ? nco_q.held_pis :
                                     nco_q.held_pp;

  wire [W-1:0] sel_value = in_nco ? nco_val :
                           in_ho  ? ho_val  :
                                    normal_val; // RQ5

  ////////////////////////////////////////////////////////////////////////////
  // Readback sequencer

  localparam dfr_pkg::dfr_rb_state_t rb_idle_c  = dfr_pkg::rb_idle;
  localparam dfr_pkg::dfr_rb_state_t rb_store_c = dfr_pkg::rb_store;
  localparam dfr_pkg::dfr_rb_state_t rb_clear_c = dfr_pkg::rb_clear;

  wire nco_entry = in_nco & (prev_state_ff != dfr_pkg::LS_NCO);
  wire idle      = (state_ff == rb_idle_c);
  wire store     = (state_ff == rb_store_c);
  wire clearing  = (state_ff == rb_clear_c);

  // A host set in the clearing cycle wins over the clear
  wire req_set   = ctrl_wr & pwdata[dfr_pkg::CTRL_REQ_BIT]; // RQ1
  wire nxt_sem   = req_set | (sem_ff & ~clearing);          // RQ3
  wire start_man = idle & sem_ff;                           // RQ1
  wire start_aut = idle & ~sem_ff & auto_pend_ff;           // RQ5
  wire nxt_auto  = (nco_entry & nco_auto_read)
                 | (auto_pend_ff & ~start_aut);
  wire [2:0] nxt_sel = ctrl_wr
      ? pwdata[dfr_pkg::CTRL_SEL_MSB:dfr_pkg::CTRL_SEL_LSB] : sel_ff;

  dfr_pkg::dfr_rb_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dfr_pkg::rb_idle:
        if (start_man || start_aut)
          nxt_state = dfr_pkg::rb_store;
      dfr_pkg::rb_store:
        nxt_state = manual_ff ? dfr_pkg::rb_clear : dfr_pkg::rb_idle; // RQ2
      dfr_pkg::rb_clear:
        nxt_state = dfr_pkg::rb_idle;
      default:
        nxt_state = dfr_pkg::rb_idle;
    endcase
  end

  wire [W-1:0] nxt_result = store ? sel_value : result_ff; // RQ2
  wire         nxt_manual = start_man ? 1'b1 : start_aut ? 1'b0 : manual_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff      <= dfr_pkg::rb_idle;
      sem_ff        <= 1'b0;
      sel_ff        <= dfr_pkg::SEL_RESET;
      result_ff     <= '0;
      manual_ff     <= 1'b0;
      auto_pend_ff  <= 1'b0;
      prev_state_ff <= dfr_pkg::LS_NORMAL;
    end
    else
    begin
      state_ff      <= nxt_state;
      sem_ff        <= nxt_sem;
      sel_ff        <= nxt_sel;
      result_ff     <= nxt_result;
      manual_ff     <= nxt_manual;
      auto_pend_ff  <= nxt_auto;
      prev_state_ff <= loop_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase error data, one nanosecond per LSB

  // The device result wins over a host write landing in the same cycle
  wire [31:0] nxt_tie = tie_result_valid ? tie_result : // RQ12 RQ13
                        tie_wr           ? pwdata     : tie_ff; // RQ14

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tie_ff <= dfr_pkg::TIE_DATA_RESET;
    else
      tie_ff <= nxt_tie;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign tie_argument  = tie_ff;
  assign readback_busy = sem_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_req_starts: assert property ( // RQ1
    @(posedge pclk) disable iff (!presetn)
    (idle && !sem_ff && !auto_pend_ff && req_set)
      |=> sem_ff ##1 (state_ff == dfr_pkg::rb_store)
          ##1 (state_ff == dfr_pkg::rb_clear) ##1 !sem_ff)
    else $error("manual readback did not run its sequence");

  a_store_first: assert property ( // RQ2
    @(posedge pclk) disable iff (!presetn)
    $fell(sem_ff) |-> ($past(state_ff) == dfr_pkg::rb_clear)
      && ($past(state_ff, 2) == dfr_pkg::rb_store)
      && (result_ff == $past(sel_value, 2)))
    else $error("request bit cleared without a stored result");

  a_sem_hold: assert property ( // RQ3
    @(posedge pclk) disable iff (!presetn)
    (sem_ff && state_ff != dfr_pkg::rb_clear) |=> sem_ff)
    else $error("request bit dropped outside the clearing step");

  a_sel_normal: assert property ( // RQ6
    @(posedge pclk) disable iff (!presetn)
    (loop_state == dfr_pkg::LS_NORMAL && sel_ff[1:0] == dfr_pkg::SEL_PIS)
      |-> (sel_value == pi_sum))
    else $error("normal state sum selection wrong");

  a_ho_low_sel: assert property ( // RQ7
    @(posedge pclk) disable iff (!presetn)
    (in_ho && !sel_ff[2]) |-> (sel_value == holdover_filter_out))
    else $error("holdover 0xx did not give filter output");

  a_ho_int_latch: assert property ( // RQ8
    @(posedge pclk) disable iff (!presetn)
    (loop_state == dfr_pkg::LS_NORMAL ##1 in_ho && sel_ff == 3'h4)
      |-> (sel_value == $past(integral_accumulator)))
    else $error("holdover 100 lost the pre-holdover integral");

  a_ho_pp_latch: assert property ( // RQ9
    @(posedge pclk) disable iff (!presetn)
    (loop_state == dfr_pkg::LS_NORMAL ##1 in_ho && sel_ff == 3'h7)
      |-> (sel_value == $past(p_part)))
    else $error("holdover 111 lost the pre-holdover proportional");

  a_nco_latched: assert property ( // RQ10
    @(posedge pclk) disable iff (!presetn)
    (loop_state == dfr_pkg::LS_NORMAL ##1 in_nco && sel_ff[1:0] == 2'h1)
      |-> (sel_value == $past(holdover_filter_out)))
    else $error("NCO read did not use the entry value");

  a_nco_from_ho: assert property ( // RQ11
    @(posedge pclk) disable iff (!presetn)
    (in_ho ##1 in_nco && sel_ff == 3'h6)
      |-> (sel_value == $past(holdover_filter_out)))
    else $error("NCO 110 from holdover not the filter output");

  a_tie_result: assert property ( // RQ12
    @(posedge pclk) disable iff (!presetn)
    tie_result_valid |=> (tie_argument == $past(tie_result)))
    else $error("phase error result not stored");

  a_resv_zero: assert property ( // RQ15
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_ctrl) |=> (prdata[7:5] == 3'h0) && !prdata[3])
    else $error("reserved control bits read nonzero");

endmodule
`default_nettype wire

// ---- verification/tb_dfr_freq_readback.sv ----
// Self-checking testbench for the frequency offset readback block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_dfr_freq_readback;
  localparam int W = 40;
  localparam logic [11:0] UNMAPPED = 12'h0C04;

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [W-1:0]  lv [4];
  logic [W-1:0]  hold [4];
  logic [W-1:0]  ncl [4];
  logic [1:0]    st;
  logic          nco_auto_read;
  logic [1:0]    tie_action_field;
  logic          tie_result_valid;
  logic [31:0]   tie_result;
  logic [31:0]   tie_argument;
  logic          readback_busy;
  logic [31:0]   tq [$];
  int            error_cnt = 0;
  int            n_compared = 0;
  int            cyc = 0;

  dfr_freq_readback #(.W(W)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .integral_accumulator(lv[0]), .holdover_filter_out(lv[1]),
    .pi_sum(lv[2]), .p_part(lv[3]), .loop_state(st),
    .nco_auto_read(nco_auto_read), .tie_action_field(tie_action_field),
    .tie_result_valid(tie_result_valid), .tie_result(tie_result),
    .tie_argument(tie_argument), .readback_busy(readback_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer, then one idle edge before the next setup
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Quantity the model expects for a selector in the present loop state
  function automatic logic [W-1:0] expq(input logic [2:0] s);
    logic [1:0] k;
    k = s[1:0];
    if (st == dfr_pkg::LS_HOLDOVER)
      return (!s[2] || k == dfr_pkg::SEL_HOF) ? lv[1] : hold[k];
    if (st == dfr_pkg::LS_NCO)
      return ncl[k];
    return lv[k];
  endfunction

  task automatic set_live(input bit keep_hof);
    for (int i = 0; i < 4; i++)
      if (!(keep_hof && i == 1))
        lv[i] <= W'({$urandom, $urandom});
    @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic chk_result(input logic [W-1:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, dfr_pkg::ADDR_RESULT_LO, 32'h0000_0000, rd, er);
    `CHK(rd, e[31:0])
    apb(1'b0, dfr_pkg::ADDR_RESULT_HI, 32'h0000_0000, rd, er);
    `CHK(rd, {24'h00_0000, e[39:32]})
  endtask

  // Manual readback with reserved bits set in the write word
  task automatic readback(input logic [2:0] s);
    logic [31:0]  rd;
    logic         er;
    logic [W-1:0] e;
    int           n;
    e = expq(s);
    apb(1'b1, dfr_pkg::ADDR_CTRL, {24'h00_0000, 3'b111, 2'b11, s}, rd, er);
    `CHK(readback_busy, 1'b1)
    n = 0;
    do
    begin
      apb(1'b0, dfr_pkg::ADDR_CTRL, 32'h0000_0000, rd, er);
      n++;
    end while (rd[4] !== 1'b0 && n < 20);
    `CHK(rd, {29'h0000_0000, s})
    `CHK(readback_busy, 1'b0)
    chk_result(e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] rd;
    logic        er;
    logic [31:0] t;
    logic [11:0] map [5];
    map = '{dfr_pkg::ADDR_CTRL, dfr_pkg::ADDR_TIE_DATA,
            dfr_pkg::ADDR_RESULT_LO, dfr_pkg::ADDR_RESULT_HI,
            dfr_pkg::ADDR_TIE_CTRL};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
      lv[i] = '0;
    st = dfr_pkg::LS_NORMAL;
    nco_auto_read = 1'b0;
    tie_action_field = 2'b00;
    tie_result_valid = 1'b0;
    tie_result = 32'h0000_0000;
    void'($urandom(32'h15da));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);

    foreach (map[i])
    begin
      apb(1'b0, map[i], 32'h0000_0000, rd, er);
      `CHK(rd, 32'h0000_0000)
    end
    `CHK(tie_argument, 32'h0000_0000)
    $display("test reset values done");

    apb(1'b1, UNMAPPED, $urandom, rd, er);
    `CHK(er, 1'b1)
    apb(1'b0, UNMAPPED, 32'h0000_0000, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, dfr_pkg::ADDR_RESULT_LO, $urandom, rd, er);
    apb(1'b1, dfr_pkg::ADDR_CTRL, 32'h0000_0005, rd, er);
    `CHK({er, readback_busy}, 2'b00)
    chk_result('0);
    $display("test refusals done");

    set_live(1'b0);
    for (int i = 0; i < 8; i++)
      readback(3'(i + 3));
    $display("test normal state done");

    // Selector 100 stands at holdover entry
    apb(1'b1, dfr_pkg::ADDR_CTRL, 32'h0000_0004, rd, er);
    hold = lv;
    st <= dfr_pkg::LS_HOLDOVER;
    @(posedge pclk);
    set_live(1'b1);
    for (int i = 0; i < 8; i++)
      readback(3'(i + 3));
    $display("test holdover done");

    // Selector 110 stands at NCO entry from holdover
    apb(1'b1, dfr_pkg::ADDR_CTRL, 32'h0000_0006, rd, er);
    ncl = '{hold[0], lv[1], lv[1], hold[3]};
    nco_auto_read <= 1'b1;
    st <= dfr_pkg::LS_NCO;
    @(posedge pclk);
    set_live(1'b0);
    repeat (4) @(posedge pclk);
    chk_result(ncl[2]);
    apb(1'b0, dfr_pkg::ADDR_CTRL, 32'h0000_0000, rd, er);
    `CHK(rd, 32'h0000_0006)
    for (int i = 0; i < 8; i++)
      readback(3'(i + 3));
    $display("test nco from holdover done");

    nco_auto_read <= 1'b0;
    // Short holdover visit with selector 111, then NCO entry with x01
    apb(1'b1, dfr_pkg::ADDR_CTRL, 32'h0000_0007, rd, er);
    st <= dfr_pkg::LS_NORMAL;
    @(posedge pclk);
    st <= dfr_pkg::LS_HOLDOVER;
    @(posedge pclk);
    st <= dfr_pkg::LS_NORMAL;
    apb(1'b1, dfr_pkg::ADDR_CTRL, 32'h0000_0001, rd, er);
    set_live(1'b0);
    ncl = lv;
    st <= dfr_pkg::LS_NCO;
    @(posedge pclk);
    set_live(1'b0);
    for (int i = 0; i < 8; i++)
      readback(3'(i + 3));
    $display("test nco from normal done");

    tie_action_field <= 2'b00;
    repeat (3)
    begin
      tq.push_back($urandom);
      apb(1'b1, dfr_pkg::ADDR_TIE_DATA, tq[$], rd, er);
      `CHK(tie_argument, tq[$])
      apb(1'b0, dfr_pkg::ADDR_TIE_DATA, 32'h0000_0000, rd, er);
      t = tq.pop_front();
      `CHK(rd, t)
    end
    tie_result <= $urandom;
    tie_result_valid <= 1'b1;
    @(posedge pclk);
    tie_result_valid <= 1'b0;
    @(posedge pclk);
    `CHK(tie_argument, tie_result)
    tie_action_field <= 2'($urandom);
    @(posedge pclk);
    apb(1'b0, dfr_pkg::ADDR_TIE_CTRL, 32'h0000_0000, rd, er);
    `CHK(rd, {30'h0000_0000, tie_action_field})
    tie_action_field <= 2'b00;
    $display("test phase error data done");

    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(tie_argument, 32'h0000_0000)
    apb(1'b0, dfr_pkg::ADDR_CTRL, 32'h0000_0000, rd, er);
    `CHK(rd, 32'h0000_0000)
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
